// ---- agc_gate_pkg.sv ----
`default_nettype none

package agc_gate_pkg;

  // Register offsets on the control port.
  localparam logic [7:0] ADDR_R_GATE = 8'h1f;
  localparam logic [7:0] ADDR_L_GAIN = 8'h20;
  localparam logic [7:0] ADDR_R_GAIN = 8'h21;
  localparam logic [7:0] ADDR_L_DEB = 8'h22;
  localparam logic [7:0] ADDR_R_DEB = 8'h23;
  localparam logic [7:0] ADDR_FLAGS = 8'h24;

  // Reset values of the stored and captured registers.
  localparam logic [7:0] GATE_RST = 8'h00;
  localparam logic [7:0] DEB_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;

  // Noise gate control layout: hysteresis, threshold, clip stepping.
  typedef struct packed {
    logic [1:0] hyst;
    logic [4:0] thr;
    logic clip;
  } gate_ctrl_s;

  // Debounce layout: noise debounce over signal debounce.
  typedef struct packed {
    logic [4:0] noise;
    logic [2:0] sig;
  } debounce_s;

  // Per-channel flag nibble, top bit first.
  typedef struct packed {
    logic pga_ok;
    logic adc_up;
    logic noise;
    logic sat;
  } chan_flags_s;

  // Live state of one channel from the AGC core and ADC.
  typedef struct packed {
    logic [7:0] agc_gain;
    logic [6:0] max_gain;
    logic [6:0] pga_applied;
    logic [6:0] pga_prog;
    logic adc_up;
    logic [6:0] level;
  } chan_in_s;

  // Debounce time base: one tick every half millisecond.
  localparam int CLK_PERIOD_PS = 5000;
  localparam int HALF_MS_PS = 500000000;
  localparam int HALF_MS_CYC = HALF_MS_PS / CLK_PERIOD_PS;

  // Noise threshold in dB below full scale: base, step.
  localparam logic [7:0] THR_BASE_DB = 8'h1e;
  localparam logic [7:0] THR_STEP_DB = 8'h02;

  // Highest gain code, also the clamp of the max gain limit.
  localparam logic [6:0] MAX_GAIN_CEIL = 7'h77;

  // Noise debounce decode: exponential part, linear part, cap.
  localparam logic [4:0] NDEB_LIN_FIRST = 5'h08;
  localparam logic [4:0] NDEB_LIN_BASE = 5'h07;
  localparam logic [4:0] NDEB_CAP_CODE = 5'h1e;
  localparam logic [11:0] NDEB_LIN_TICKS = 12'h080;
  localparam logic [11:0] NDEB_CAP_TICKS = 12'hc00;
  localparam int TICK_W = 12;

endpackage

`default_nettype wire

// ---- agc_gate_detect.sv ----
`timescale 1ns/1ps
`default_nettype none

module agc_gate_detect (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Time base and settings.
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic [7:0] i_thr_db,
  input wire logic [1:0] i_hyst_db,
  input wire logic [11:0] i_noise_ticks,
  input wire logic [11:0] i_sig_ticks,
  // Measured level in dB below full scale.
  input wire logic [6:0] i_level,
  // Debounced state: high while the channel is below threshold.
  output logic o_noise
);

  logic noise_reg;
  logic [11:0] cnt_reg;
  logic want_noise;
  logic want_sig;
  logic pending;
  logic [11:0] target;

  // Entering noise needs the level under threshold; leaving it needs
  // the level above threshold by the hysteresis margin.
  always_comb begin
    want_noise = {1'b0, i_level} > i_thr_db;
    want_sig = ({2'b00, i_level} + {7'h00, i_hyst_db}) <
               {1'b0, i_thr_db};
    pending = noise_reg ? want_sig : want_noise;
    target = noise_reg ? i_sig_ticks : i_noise_ticks;
  end

  // A change is taken once it has held for the whole debounce time.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      noise_reg <= 1'b0;
      cnt_reg <= 12'h000;
    end else if (!i_enable) begin
      noise_reg <= 1'b0;
      cnt_reg <= 12'h000;
    end else if (!pending) begin
      cnt_reg <= 12'h000;
    end else if (cnt_reg >= target) begin
      noise_reg <= ~noise_reg;
      cnt_reg <= 12'h000;
    end else if (i_tick) begin
      cnt_reg <= cnt_reg + 12'h001;
    end
  end

  assign o_noise = noise_reg;

endmodule // agc_gate_detect

`default_nettype wire

// ---- agc_noise_gate_status_regs.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [RQ1] Right gate hysteresis in bits 7:6: off, then 1, 2, 3 dB.
// [RQ2] Right threshold code 0 disables detection; 1 is -30 dB, 2 dB steps.
// [RQ3] Bit 0 of right gate control enables right clip stepping.
// [RQ4] Left gain readout: applied AGC gain, two's complement half dB.
// [RQ5] Right gain readout: same encoding, up to +59.5 dB.
// [RQ6] Left noise debounce: 0 to 32 ms doubling, then 64 ms steps; the code gives codes 30 and 31 both 1536 ms.
// [RQ7] Left signal debounce: zero, then 0.5 ms doubling to 32 ms.
// [RQ8] Right noise debounce uses the same mapping as the left one.
// [RQ9] Right signal debounce: zero, then 0.5 ms doubling to 32 ms.
// [RQ10] Double rate audio mode changes the effective debounce times.
// [RQ11] Flag bits 7 and 3 show PGA applied gain equal to programmed.
// [RQ12] Flag bits 6 and 2 show left and right ADC powered up.
// [RQ13] Flag bits 5 and 1 show signal below the noise threshold.
// [RQ14] Flag bits 4 and 0 show applied gain at the maximum allowed.
// [RQ15] Maximum allowed gain is a seven-bit half dB limit per channel.
// [RQ16] Status tracks live state; reads are harmless, writes ignored.

module agc_noise_gate_status_regs #(
  parameter int P_HALF_MS_CYC = agc_gate_pkg::HALF_MS_CYC
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Control port register access.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // Live state from the AGC core and the ADC channels.
  input wire agc_gate_pkg::chan_in_s i_left,
  input wire agc_gate_pkg::chan_in_s i_right,
  // Left gate control held in the neighbouring register.
  input wire agc_gate_pkg::gate_ctrl_s i_left_gate,
  // Mode input.
  input wire logic i_double_rate_audio,
  // Settings toward the AGC core.
  output agc_gate_pkg::gate_ctrl_s o_right_gate,
  output agc_gate_pkg::debounce_s o_left_deb,
  output agc_gate_pkg::debounce_s o_right_deb,
  // Status toward the AGC core.
  output logic [7:0] o_flags
);

  // Divider width and the end counts for the normal and double rate ticks.
  localparam int DIV_W = $clog2(P_HALF_MS_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_FULL =
    DIV_W'(P_HALF_MS_CYC - 1);
  localparam logic [DIV_W-1:0] DIV_HALF =
    DIV_W'((P_HALF_MS_CYC / 2) - 1);

  // The half-rate divider needs at least two cycles per tick.
  if (P_HALF_MS_CYC < 2) begin : g_bad_div
    $error("P_HALF_MS_CYC must be at least 2");
  end

  // An odd divide would make the double rate tick period inexact.
  if ((P_HALF_MS_CYC % 2) != 0) begin : g_odd_div
    $error("P_HALF_MS_CYC must be even");
  end

  // Stored control registers.
  // All three reset to zero and change only on a write to their offset.
  agc_gate_pkg::gate_ctrl_s r_gate_reg;
  agc_gate_pkg::debounce_s l_deb_reg;
  agc_gate_pkg::debounce_s r_deb_reg;

  // Captured live state.
  // These are sampled every edge and never written through the port.
  logic [7:0] l_gain_reg;
  logic [7:0] r_gain_reg;
  agc_gate_pkg::chan_flags_s l_flags_reg;
  agc_gate_pkg::chan_flags_s r_flags_reg;

  // Read data and time base.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_end;
  logic tick_reg;

  // Decoded detector settings.
  logic [7:0] l_thr_db;
  logic [7:0] r_thr_db;
  logic [11:0] l_noise_ticks;
  logic [11:0] l_sig_ticks;
  logic [11:0] r_noise_ticks;
  logic [11:0] r_sig_ticks;
  logic l_noise;
  logic r_noise;

  // Write strobes, one per writable register.
  logic wr_r_gate;
  logic wr_l_deb;
  logic wr_r_deb;

  // Threshold in dB below full scale for a nonzero code.
  // The top code gives 90 dB, well inside the eight-bit result.
  function automatic logic [7:0] thr_db(input logic [4:0] code);
    logic [7:0] steps;
    steps = {3'b000, code} - 8'h01;
    return agc_gate_pkg::THR_BASE_DB +
           8'(steps * agc_gate_pkg::THR_STEP_DB);
  endfunction

  // Signal debounce in half-millisecond ticks.
  // Code one is a single tick; each higher code doubles it.
  function automatic logic [11:0] sig_ticks(input logic [2:0] code);
    logic [11:0] t;
    t = 12'h000;
    if (code != 3'b000) begin
      t = 12'h001 << (code - 3'b001);
    end
    return t;
  endfunction

  // Noise debounce in half-millisecond ticks.
  // Below code 8 the time doubles; from code 8 to code 29 it grows in equal steps.
  // The two top codes share the longest time, so nothing runs past it.
  function automatic logic [11:0] noise_ticks(input logic [4:0] code);
    logic [11:0] t;
    logic [4:0] excess;
    t = 12'h000;
    excess = code - agc_gate_pkg::NDEB_LIN_BASE;
    if (code == 5'h00) begin
      t = 12'h000;
    end else if (code < agc_gate_pkg::NDEB_LIN_FIRST) begin
      t = 12'h001 << (code - 5'h01);
    end else if (code >= agc_gate_pkg::NDEB_CAP_CODE) begin
      t = agc_gate_pkg::NDEB_CAP_TICKS;
    end else begin
      t = 12'({7'h00, excess} * agc_gate_pkg::NDEB_LIN_TICKS);
    end
    return t;
  endfunction

  // Saturation: applied gain equals the clamped limit.
  // Limit codes above the top gain code all mean that same ceiling.
  function automatic logic at_max(input logic [7:0] gain,
                                  input logic [6:0] limit);
    logic [6:0] lim;
    lim = limit;
    if (limit > agc_gate_pkg::MAX_GAIN_CEIL) begin
      lim = agc_gate_pkg::MAX_GAIN_CEIL;
    end
    return gain == {1'b0, lim};
  endfunction

  // Address decode of writes; read-only offsets get no strobe.
  // A write aimed at a gain or flag offset is thus dropped silently.
  always_comb begin
    wr_r_gate = i_reg_wr && (i_reg_addr == agc_gate_pkg::ADDR_R_GATE);
    wr_l_deb = i_reg_wr && (i_reg_addr == agc_gate_pkg::ADDR_L_DEB);
    wr_r_deb = i_reg_wr && (i_reg_addr == agc_gate_pkg::ADDR_R_DEB);
  end

  // Right noise gate control: hysteresis, threshold, clip stepping.
  // Its fields go straight out to the AGC core on o_right_gate.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_gate_reg <= agc_gate_pkg::GATE_RST;
    end else if (wr_r_gate) begin
      r_gate_reg <= i_reg_wdata; // [RQ1] [RQ2] [RQ3]
    end
  end

  // Left debounce settings.
  // Both fields are decoded into tick counts further down.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      l_deb_reg <= agc_gate_pkg::DEB_RST;
    end else if (wr_l_deb) begin
      l_deb_reg <= i_reg_wdata; // [RQ6] [RQ7]
    end
  end

  // Right debounce settings.
  // They are decoded the same way as the left register.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_deb_reg <= agc_gate_pkg::DEB_RST;
    end else if (wr_r_deb) begin
      r_deb_reg <= i_reg_wdata; // [RQ8] [RQ9]
    end
  end

  // Double rate audio runs the detectors twice as fast, so every
  // debounce time halves against its nominal value.
  always_comb begin
    div_end = i_double_rate_audio ? DIV_HALF : DIV_FULL; // [RQ10]
  end

  // Half-millisecond tick divider. The tick is a one-cycle enable, so the
  // detectors stay on the single clock; a mode switch past the new end
  // restarts the count at once, so the first tick after it may come early.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
    end else if (div_reg >= div_end) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
      tick_reg <= 1'b0;
    end
  end

  // Decode thresholds and debounce times for both detectors.
  // The left threshold comes in from the register outside this block.
  always_comb begin
    l_thr_db = thr_db(i_left_gate.thr);
    r_thr_db = thr_db(r_gate_reg.thr); // [RQ2]
    l_noise_ticks = noise_ticks(l_deb_reg.noise); // [RQ6]
    l_sig_ticks = sig_ticks(l_deb_reg.sig); // [RQ7]
    r_noise_ticks = noise_ticks(r_deb_reg.noise); // [RQ8]
    r_sig_ticks = sig_ticks(r_deb_reg.sig); // [RQ9]
  end

  // Left noise detector; a zero threshold code keeps it idle.
  // Its hysteresis also comes from outside, with the left threshold.
  agc_gate_detect u_left_detect (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_tick(tick_reg),
    .i_enable(i_left_gate.thr != 5'h00),
    .i_thr_db(l_thr_db),
    .i_hyst_db(i_left_gate.hyst),
    .i_noise_ticks(l_noise_ticks),
    .i_sig_ticks(l_sig_ticks),
    .i_level(i_left.level),
    .o_noise(l_noise)
  );

  // Right noise detector with the hysteresis from its own register.
  // Both detectors share the one divider tick.
  agc_gate_detect u_right_detect (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_tick(tick_reg),
    .i_enable(r_gate_reg.thr != 5'h00), // [RQ2]
    .i_thr_db(r_thr_db),
    .i_hyst_db(r_gate_reg.hyst), // [RQ1]
    .i_noise_ticks(r_noise_ticks),
    .i_sig_ticks(r_sig_ticks),
    .i_level(i_right.level),
    .o_noise(r_noise)
  );

  // Applied gain readouts follow the AGC core every cycle.
  // The readout lags the core by one edge, which keeps it on a flip-flop.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      l_gain_reg <= agc_gate_pkg::GAIN_RST;
      r_gain_reg <= agc_gate_pkg::GAIN_RST;
    end else begin
      l_gain_reg <= i_left.agc_gain; // [RQ4] [RQ16]
      r_gain_reg <= i_right.agc_gain; // [RQ5] [RQ16]
    end
  end

  // Left flag nibble, rebuilt from live state every cycle.
  // No flag is ever cleared by software, so no set and clear can collide.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      l_flags_reg <= '0;
    end else begin
      l_flags_reg.pga_ok <=
        i_left.pga_applied == i_left.pga_prog; // [RQ11]
      l_flags_reg.adc_up <= i_left.adc_up; // [RQ12]
      l_flags_reg.noise <= l_noise; // [RQ13]
      l_flags_reg.sat <=
        at_max(i_left.agc_gain, i_left.max_gain); // [RQ14] [RQ15]
    end
  end

  // Right flag nibble, rebuilt from live state every cycle.
  // It fills the low half of the flag byte.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      r_flags_reg <= '0;
    end else begin
      r_flags_reg.pga_ok <=
        i_right.pga_applied == i_right.pga_prog; // [RQ11]
      r_flags_reg.adc_up <= i_right.adc_up; // [RQ12]
      r_flags_reg.noise <= r_noise; // [RQ13]
      r_flags_reg.sat <=
        at_max(i_right.agc_gain, i_right.max_gain); // [RQ14] [RQ15]
    end
  end

  // Read multiplexer; unknown offsets read as zero.
  // It sees the captured copies, so a read shows state one edge old.
  always_comb begin
    case (i_reg_addr)
      agc_gate_pkg::ADDR_R_GATE: begin
        rdata_next = r_gate_reg;
      end
      agc_gate_pkg::ADDR_L_GAIN: begin
        rdata_next = l_gain_reg; // [RQ4]
      end
      agc_gate_pkg::ADDR_R_GAIN: begin
        rdata_next = r_gain_reg; // [RQ5]
      end
      agc_gate_pkg::ADDR_L_DEB: begin
        rdata_next = l_deb_reg;
      end
      agc_gate_pkg::ADDR_R_DEB: begin
        rdata_next = r_deb_reg;
      end
      agc_gate_pkg::ADDR_FLAGS: begin
        rdata_next = {l_flags_reg, r_flags_reg};
      end
      default: begin
        rdata_next = agc_gate_pkg::UNMAPPED_RD;
      end
    endcase
  end

  // Read data is captured on a read strobe and held after it; a read
  // changes no state anywhere else in the block.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= agc_gate_pkg::UNMAPPED_RD;
    end else if (i_reg_rd) begin
      rdata_reg <= rdata_next; // [RQ16]
    end
  end

  // Every output is a flip-flop.
  // The core sees a written setting on the edge after the write.
  assign o_reg_rdata = rdata_reg;
  assign o_right_gate = r_gate_reg;
  assign o_left_deb = l_deb_reg;
  assign o_right_deb = r_deb_reg;
  assign o_flags = {l_flags_reg, r_flags_reg};

endmodule // agc_noise_gate_status_regs

`default_nettype wire

// ---- agc_noise_gate_status_regs_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module agc_gate_checker #(
  parameter int P_HALF_MS_CYC = agc_gate_pkg::HALF_MS_CYC
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // Register port.
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Live channel state and settings out.
  input wire agc_gate_pkg::chan_in_s i_left,
  input wire agc_gate_pkg::chan_in_s i_right,
  input wire agc_gate_pkg::gate_ctrl_s o_right_gate,
  input wire agc_gate_pkg::debounce_s o_left_deb,
  input wire agc_gate_pkg::debounce_s o_right_deb,
  input wire logic [7:0] o_flags
);
  logic up_reg;
  logic [1:0] sat_w;

  // Armed from the second edge, once the flags hold sampled live state.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) up_reg <= 1'b0;
    else up_reg <= 1'b1;
  end

  // Saturation seen at the inputs, limit clamped to the top gain code.
  assign sat_w[1] = i_left.agc_gain ==
    {1'b0, (i_left.max_gain > 7'h77) ? 7'h77 : i_left.max_gain};
  assign sat_w[0] = i_right.agc_gain ==
    {1'b0, (i_right.max_gain > 7'h77) ? 7'h77 : i_right.max_gain};

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_pga_ok;
    up_reg |-> o_flags[7] == ($past(i_left.pga_applied) ==
      $past(i_left.pga_prog)) && o_flags[3] ==
      ($past(i_right.pga_applied) == $past(i_right.pga_prog));
  endproperty
  a_pga_ok: assert property (p_pga_ok)
    else $error("pga status flag wrong");
  property p_adc_up;
    up_reg |-> o_flags[6] == $past(i_left.adc_up)
      && o_flags[2] == $past(i_right.adc_up);
  endproperty
  a_adc_up: assert property (p_adc_up)
    else $error("adc power flag wrong");
  property p_sat;
    up_reg |-> {o_flags[4], o_flags[0]} == $past(sat_w);
  endproperty
  a_sat: assert property (p_sat)
    else $error("saturation flag wrong");
  property p_lgain;
    up_reg && i_reg_rd && i_reg_addr == 8'h20
      |=> o_reg_rdata == $past(i_left.agc_gain, 2);
  endproperty
  a_lgain: assert property (p_lgain)
    else $error("left gain readout wrong");
  property p_rgain;
    up_reg && i_reg_rd && i_reg_addr == 8'h21
      |=> o_reg_rdata == $past(i_right.agc_gain, 2);
  endproperty
  a_rgain: assert property (p_rgain)
    else $error("right gain readout wrong");
  property p_gate_wr;
    i_reg_wr && i_reg_addr == 8'h1f |=> o_right_gate == $past(i_reg_wdata);
  endproperty
  a_gate_wr: assert property (p_gate_wr)
    else $error("gate control write lost");
  property p_ldeb_wr;
    i_reg_wr && i_reg_addr == 8'h22 |=> o_left_deb == $past(i_reg_wdata);
  endproperty
  a_ldeb_wr: assert property (p_ldeb_wr)
    else $error("left debounce write lost");
  property p_rdeb_wr;
    i_reg_wr && i_reg_addr == 8'h23 |=> o_right_deb == $past(i_reg_wdata);
  endproperty
  a_rdeb_wr: assert property (p_rdeb_wr)
    else $error("right debounce write lost");
  property p_cfg_hold;
    !(i_reg_wr && i_reg_addr inside {8'h1f, 8'h22, 8'h23})
      |=> $stable({o_right_gate, o_left_deb, o_right_deb});
  endproperty
  a_cfg_hold: assert property (p_cfg_hold)
    else $error("settings changed without a write");
  property p_unmapped;
    i_reg_rd && !(i_reg_addr inside {[8'h1f:8'h24]}) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_noise_off;
    (o_right_gate.thr == 5'h00) [*3] |-> !o_flags[1];
  endproperty
  a_noise_off: assert property (p_noise_off)
    else $error("noise flag set while detection off");

  c_sat: cover property ($rose(o_flags[0]));
  c_noise: cover property ($rose(o_flags[1]));
  c_flag_rd: cover property (i_reg_rd && i_reg_addr == 8'h24);
endmodule // agc_gate_checker

bind agc_noise_gate_status_regs agc_gate_checker #(
  .P_HALF_MS_CYC(P_HALF_MS_CYC)
) u_chk (.i_ref_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
  .i_reg_rd, .o_reg_rdata, .i_left, .i_right, .o_right_gate, .o_left_deb,
  .o_right_deb, .o_flags);

`default_nettype wire

// ---- agc_noise_gate_status_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
  end end

module agc_noise_gate_status_regs_tb_top;
  localparam int P = 8;
  logic i_ref_clk, i_rstn, i_reg_wr, i_reg_rd, i_double_rate_audio;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, o_flags;
  logic [7:0] m_gate, m_ldeb, m_rdeb;
  agc_gate_pkg::chan_in_s i_left, i_right;
  agc_gate_pkg::gate_ctrl_s i_left_gate, o_right_gate;
  agc_gate_pkg::debounce_s o_left_deb, o_right_deb;
  int bad_count, samples_checked, n;
  int codes[4] = '{0, 3, 8, 30};
  int ticks[4] = '{0, 4, 128, 3072};
  logic [31:0] seed;

  agc_noise_gate_status_regs #(.P_HALF_MS_CYC(P)) dut (.i_ref_clk,
    .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
    .i_left, .i_right, .i_left_gate, .i_double_rate_audio, .o_right_gate,
    .o_left_deb, .o_right_deb, .o_flags);

  // Free-running 200 MHz clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // Xorshift source with a fixed start.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected flag nibble; noise stays clear while the level sits at 0 dB.
  function automatic logic [3:0] nib(input agc_gate_pkg::chan_in_s c);
    logic [6:0] lim;
    lim = (c.max_gain > 7'h77) ? 7'h77 : c.max_gain;
    return {c.pga_applied == c.pga_prog, c.adc_up, 1'b0,
      c.agc_gain == {1'b0, lim}};
  endfunction

  // Random channel state; half the time the gain sits on its limit.
  function automatic agc_gate_pkg::chan_in_s rand_chan();
    agc_gate_pkg::chan_in_s c;
    c.agc_gain = 8'(rnd());
    c.max_gain = 7'(rnd());
    c.pga_applied = 7'(rnd());
    c.pga_prog = rnd() & 1 ? c.pga_applied : 7'(rnd());
    c.adc_up = 1'(rnd());
    c.level = 7'h00;
    if (rnd() & 1) begin
      c.agc_gain = {1'b0, c.max_gain > 7'h77 ? 7'h77 : c.max_gain};
    end
    return c;
  endfunction

  task automatic step();
    @(posedge i_ref_clk);
    #1;
  endtask

  // One write; the strobe drops for a cycle so drivers never clash.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    step();
    i_reg_wr = 1'b0;
    step();
  endtask

  // One read, compared with the model value.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    step();
    i_reg_rd = 1'b0;
    `CHK(o_reg_rdata, e)
    step();
  endtask

  // Waits for a flag bit under a bound, then checks the earliest time.
  task automatic flip(input int b, input logic v, input int lo, input int hi);
    n = 0;
    while (o_flags[b] !== v && n <= hi) begin
      step();
      n++;
    end
    if (n > hi) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, o_flags[b], v);
    end
    `CHK(n >= lo, 1'b1)
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: reset values, random access, then debounce timing.
  initial begin
    seed = 32'h00004efa; // Fixed start value, 20218.
    i_rstn = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_left = '0;
    i_right = '0;
    i_left_gate = '0;
    i_double_rate_audio = 1'b0;
    repeat (5) @(posedge i_ref_clk);
    #1;
    i_rstn = 1'b1;
    step();
    for (int a = 8'h1f; a < 8'h24; a++) rd_chk(8'(a), 8'h00);
    rd_chk(8'h1e, 8'h00);
    rd_chk(8'h24, {nib(i_left), nib(i_right)});
    for (int i = 0; i < 30; i++) begin
      i_left = rand_chan();
      i_right = rand_chan();
      i_left_gate = 8'(rnd());
      m_gate = 8'(rnd());
      m_ldeb = 8'(rnd());
      m_rdeb = 8'(rnd());
      wr(8'h1f, m_gate);
      wr(8'h22, m_ldeb);
      wr(8'h23, m_rdeb);
      wr(8'h20 + 8'(i % 2), 8'(rnd()));
      wr(8'h24, 8'(rnd()));
      `CHK(o_right_gate, m_gate)
      `CHK(o_left_deb, m_ldeb)
      `CHK(o_right_deb, m_rdeb)
      rd_chk(8'h1f, m_gate);
      rd_chk(8'h23, m_rdeb);
      rd_chk(8'h20, i_left.agc_gain);
      rd_chk(8'h21, i_right.agc_gain);
      rd_chk(8'h24, {nib(i_left), nib(i_right)});
      rd_chk(8'h80 | 8'(rnd()), 8'h00);
    end
    // Right threshold code 5 sits 38 dB down, hysteresis 3 dB.
    wr(8'h23, {5'd2, 3'd1});
    wr(8'h1f, {2'b11, 5'd5, 1'b0});
    i_right.level = 7'd38;
    repeat (3 * P) step();
    `CHK(o_flags[1], 1'b0)
    i_right.level = 7'd39;
    flip(1, 1'b1, P, 3 * P + 4);
    i_right.level = 7'd35;
    repeat (3 * P) step();
    `CHK(o_flags[1], 1'b1)
    i_right.level = 7'd34;
    flip(1, 1'b0, 0, 2 * P + 4);
    wr(8'h1f, 8'h00);
    i_right.level = 7'h7f;
    repeat (3 * P) step();
    `CHK(o_flags[1], 1'b0)
    // Left at the deepest threshold with double rate halving the ticks.
    i_double_rate_audio = 1'b1;
    i_left_gate = {2'b00, 5'h1f, 1'b0};
    foreach (codes[k]) begin
      wr(8'h22, {5'(codes[k]), 3'd0});
      i_left.level = 7'd91;
      flip(5, 1'b1, (ticks[k] - 1) * P / 2,
        (ticks[k] + 1) * P / 2 + 4);
      i_left.level = 7'd89;
      flip(5, 1'b0, 0, P + 4);
    end
    wrap_up();
  end
endmodule // agc_noise_gate_status_regs_tb_top

`default_nettype wire
